// *** core/msio_core.sv ***
// Core end: shift/rotate execution, port input/output and reset filter
`timescale 1ns/100ps
module msio_core (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  input  wire logic [msio_pkg::INSTR_W-1:0]  i_instr,
  msio_if.core                               port,
  output logic                               o_instr_taken,
  output logic                               o_carry,
  output logic                               o_zero,
  output logic                               o_int_rst
);
  import msio_pkg::*;

  logic [DATA_W-1:0] regs_r [REG_CNT];
  logic [RST_FILT-1:0] filt_r = '1;
  logic               rst_s1_r;
  logic               rst_s2_r;
  logic               int_rst;
  msio_phase_t        phase_r;
  logic [INSTR_W-1:0] ir_r;
  logic [DATA_W-1:0]  shift_nxt;
  logic               cy_nxt;
  logic               fill;

  ////////////////////////////////////////////////////////////////////
  // Reset conditioning: two-flop sampling, then a shift filter that
  // holds internal reset for RST_FILT cycles after release. The filter
  // starts full, so a tied-low input still gives a power-up reset.
  always_ff @(posedge i_clk_sys) begin
    rst_s1_r <= i_rst;
    rst_s2_r <= rst_s1_r;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || rst_s2_r) begin
      filt_r <= '1;
    end else begin
      filt_r <= {filt_r[RST_FILT-2:0], 1'b0};
    end
  end

  assign int_rst = filt_r[RST_FILT-1];
  always_ff @(posedge i_clk_sys) begin
    o_int_rst <= int_rst;
  end

  ////////////////////////////////////////////////////////////////////
  // Two-phase sequencer: instruction latched in fetch, acted on in exec.
  // Unknown opcodes still spend both cycles, so program timing is fixed.
  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      phase_r <= PH_FETCH;
    end else begin
      case (phase_r)
        PH_FETCH: begin
          phase_r <= PH_EXEC;
        end
        PH_EXEC: begin
          phase_r <= PH_FETCH;
        end
        default: begin
          phase_r <= PH_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      ir_r <= '0;
    end else if (phase_r == PH_FETCH) begin
      ir_r <= i_instr;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      o_instr_taken <= 1'b0;
    end else begin
      o_instr_taken <= (phase_r == PH_FETCH);
    end
  end

  function automatic logic is_opc(input logic [INSTR_W-1:0] ins, input logic [3:0] opc);
    return ins[OPC_HI:OPC_LO] == opc;
  endfunction

  function automatic logic is_in_op(input logic [INSTR_W-1:0] ins);
    return is_opc(ins, OPC_IN_K) || is_opc(ins, OPC_IN_R);
  endfunction

  function automatic logic is_out_op(input logic [INSTR_W-1:0] ins);
    return is_opc(ins, OPC_OUT_K) || is_opc(ins, OPC_OUT_R);
  endfunction

  // Indirect forms take the port number from the register in the source field
  function automatic logic is_indirect(input logic [INSTR_W-1:0] ins);
    return is_opc(ins, OPC_IN_R) || is_opc(ins, OPC_OUT_R);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Shift and rotate datapath
  always_comb begin
    logic [DATA_W-1:0] op;
    op        = regs_r[ir_r[DST_HI:DST_LO]];
    fill      = 1'b0;
    shift_nxt = op;
    cy_nxt    = o_carry;
    if (ir_r[DIR_BIT]) begin
      cy_nxt = op[0];
      case (ir_r[VAR_HI:0])
        VAR_ZERO:  fill = 1'b0;
        VAR_ONE:   fill = 1'b1;
        VAR_EXT_R: fill = op[DATA_W-1];
        VAR_CARRY: fill = o_carry;
        VAR_ROT_R: fill = op[0];
        default:   fill = 1'b0;
      endcase
      shift_nxt = {fill, op[DATA_W-1:1]};
    end else begin
      cy_nxt = op[DATA_W-1];
      case (ir_r[VAR_HI:0])
        VAR_ZERO:  fill = 1'b0;
        VAR_ONE:   fill = 1'b1;
        VAR_EXT_L: fill = op[0];
        VAR_CARRY: fill = o_carry;
        VAR_ROT_L: fill = op[DATA_W-1];
        default:   fill = 1'b0;
      endcase
      shift_nxt = {op[DATA_W-2:0], fill};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file writes: only the named register changes
  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      for (int i = 0; i < REG_CNT; i++) begin
        regs_r[i] <= RST_DATA;
      end
    end else if (phase_r == PH_EXEC) begin
      if (is_opc(ir_r, OPC_SHIFT)) begin
        regs_r[ir_r[DST_HI:DST_LO]] <= shift_nxt;
      end else if (is_in_op(ir_r)) begin
        regs_r[ir_r[DST_HI:DST_LO]] <= port.in_bus;
      end
    end
  end

  // Flags move on shifts only; port operations leave them alone
  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      o_carry <= 1'b0;
    end else if (phase_r == PH_EXEC && is_opc(ir_r, OPC_SHIFT)) begin
      o_carry <= cy_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      o_zero <= 1'b0;
    end else if (phase_r == PH_EXEC && is_opc(ir_r, OPC_SHIFT)) begin
      o_zero <= (shift_nxt == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Port side. Select and data are set at the fetch edge and held until
  // the next port instruction; set on the same edge as the strobes, so user decode gets one cycle too.
  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      port.port_select <= '0;
    end else if (phase_r == PH_FETCH) begin
      if (is_indirect(i_instr)) begin
        port.port_select <= regs_r[i_instr[SRC_HI:SRC_LO]];
      end else if (is_in_op(i_instr) || is_out_op(i_instr)) begin
        port.port_select <= i_instr[PORT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      port.out_bus <= '0;
    end else if (phase_r == PH_FETCH && is_out_op(i_instr)) begin
      port.out_bus <= regs_r[i_instr[DST_HI:DST_LO]];
    end
  end

  // Strobes rise at the fetch edge so they sit in the exec cycle; the read
  // strobe thus ends on the very edge that loads the register.
  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      port.read_strobe <= 1'b0;
    end else begin
      port.read_strobe <= (phase_r == PH_FETCH) && is_in_op(i_instr);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (int_rst) begin
      port.write_strobe <= 1'b0;
    end else begin
      port.write_strobe <= (phase_r == PH_FETCH) && is_out_op(i_instr);
    end
  end
endmodule // msio_core

// *** core/msio_pkg.sv ***
// Package of constants and types for the shift, port and reset block
// Notes on behaviour
// - Right variants decoded from instruction bits 2..0
// - Left variants decoded from instruction bits 2..0
// - Shifts rewrite one register and update flags
// - Input loads input bus into register, flags kept
// - Port address from constant or another register
// - Output drives source register onto output bus
// - Far logic presents data for decoded select
// - Far logic captures output on write strobe
// - Read strobe every input; far may ignore
// - Port select set at end of first cycle, stable through second
// - Write strobe only in second cycle
// - Read strobe second cycle, marks capture edge
// - Select and strobe paths both single-cycle constrained
// - Internal reset controller plus user reset
// - Reset sampled synchronously, release filtered
// - Reset may be tied low; filter still runs
// - Every instruction takes two clock cycles
package msio_pkg;
  localparam int DATA_W    = 8;
  localparam int PORT_W    = 8;
  localparam int INSTR_W   = 16;
  localparam int REG_CNT   = 16;
  localparam int REG_AW    = 4;
  localparam int RST_FILT  = 4;
  // Instruction field positions
  localparam int OPC_HI    = 15;
  localparam int OPC_LO    = 12;
  localparam int DST_HI    = 11;
  localparam int DST_LO    = 8;
  localparam int SRC_HI    = 7;
  localparam int SRC_LO    = 4;
  localparam int DIR_BIT   = 3;
  localparam int VAR_HI    = 2;
  // Opcode encodings
  localparam logic [3:0] OPC_SHIFT   = 4'hd;
  localparam logic [3:0] OPC_IN_K    = 4'ha;
  localparam logic [3:0] OPC_IN_R    = 4'hb;
  localparam logic [3:0] OPC_OUT_K   = 4'he;
  localparam logic [3:0] OPC_OUT_R   = 4'hf;
  // Shift variant codes in bits 2..0
  localparam logic [2:0] VAR_ZERO    = 3'h6;
  localparam logic [2:0] VAR_ONE     = 3'h7;
  localparam logic [2:0] VAR_EXT_R   = 3'h2;
  localparam logic [2:0] VAR_EXT_L   = 3'h4;
  localparam logic [2:0] VAR_CARRY   = 3'h0;
  localparam logic [2:0] VAR_ROT_R   = 3'h4;
  localparam logic [2:0] VAR_ROT_L   = 3'h2;
  localparam logic [7:0] RST_DATA    = 8'h00;
  typedef enum logic {PH_FETCH, PH_EXEC} msio_phase_t;
endpackage

// *** core/msio_if.sv ***
// Interface joining the core port side and the user port logic
`timescale 1ns/100ps
interface msio_if;
  import msio_pkg::*;
  logic [PORT_W-1:0] port_select;
  logic [DATA_W-1:0] in_bus;
  logic [DATA_W-1:0] out_bus;
  logic              read_strobe;
  logic              write_strobe;
  modport core (output port_select, output out_bus, output read_strobe,
                output write_strobe, input in_bus);
  modport user (input port_select, input out_bus, input read_strobe,
                input write_strobe, output in_bus);
endinterface

// *** core/msio_user.sv ***
// User end: port decode, input data mux and output capture registers
`timescale 1ns/100ps
module msio_user #(
  parameter int NPORTS = 4
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  msio_if.user                               port,
  input  wire logic [msio_pkg::DATA_W-1:0]   i_in_data [NPORTS],
  output logic      [msio_pkg::DATA_W-1:0]   o_out_data [NPORTS],
  output logic                               o_read_done
);
  import msio_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Input mux is combinational: select changes on the same edge as the read
  // strobe, so this path has a one-cycle budget.
  always_comb begin
    port.in_bus = '0;
    for (int i = 0; i < NPORTS; i++) begin
      if (port.port_select == PORT_W'(i)) begin
        port.in_bus = i_in_data[i];
      end
    end
  end

  // Capture only on the write strobe, the single-cycle timed signal
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < NPORTS; i++) begin
        o_out_data[i] <= '0;
      end
    end else if (port.write_strobe) begin
      for (int i = 0; i < NPORTS; i++) begin
        if (port.port_select == PORT_W'(i)) begin
          o_out_data[i] <= port.out_bus;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_read_done <= 1'b0;
    end else begin
      o_read_done <= port.read_strobe;
    end
  end
endmodule // msio_user

// *** testbench/msio_sva.sv ***
// Checker for port strobes, select hold and reset filter
`timescale 1ns/100ps
module msio_sva (
  input wire logic                        i_clk_sys,
  input wire logic                        i_rst,
  input wire logic [msio_pkg::PORT_W-1:0] port_select,
  input wire logic [msio_pkg::DATA_W-1:0] out_bus,
  input wire logic                        read_strobe,
  input wire logic                        write_strobe,
  input wire logic                        o_instr_taken,
  input wire logic                        o_int_rst
);
  import msio_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////
  property p_wr_second; write_strobe |-> o_instr_taken; endproperty
  a_wr_second: assert property (p_wr_second) else $error("write strobe in first cycle");
  property p_rd_second; read_strobe |-> o_instr_taken; endproperty
  a_rd_second: assert property (p_rd_second) else $error("read strobe in first cycle");
  // Select and data must outlive the strobe edge, the edge at which far logic captures
  property p_wr_hold; write_strobe |=> $stable(port_select) && $stable(out_bus); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("select or data moved after write");
  property p_rd_hold; read_strobe |=> $stable(port_select); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("select moved after read");
  property p_one_pulse; read_strobe || write_strobe |=> !read_strobe && !write_strobe; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("strobe longer than one cycle");
  property p_taken_alt; o_instr_taken |=> !o_instr_taken; endproperty
  a_taken_alt: assert property (p_taken_alt) else $error("instruction not two cycles");
  property p_rst_force; disable iff (1'b0) i_rst |-> ##2 o_int_rst; endproperty
  a_rst_force: assert property (p_rst_force) else $error("user reset ignored");
  // Two sync flops, four filter stages and the output flop: seven cycles
  property p_rst_hold; $fell(i_rst) |-> o_int_rst [*7] ##1 !o_int_rst; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset release not filtered");
  ////////////////////////////////////////////////////////////////
  c_write: cover property (write_strobe);
  c_read: cover property (read_strobe);
  c_release: cover property ($fell(o_int_rst));
endmodule // msio_sva

// *** testbench/mcu_shift_io_port_reset_bench.sv ***
// Bench joining core and user ends over the port interface
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module mcu_shift_io_port_reset_bench;
  import msio_pkg::*;
  logic         i_clk_sys = 0, i_rst = 1, c, z, o_instr_taken, o_carry, o_zero, o_int_rst, o_read_done;
  logic [15:0]  i_instr = '0;
  logic [7:0]   in_data [4], out_data [4], m [16];
  logic [3:0]   r;
  int           n_errors = 0, n_checks = 0, seed = 47994;
  msio_if port_if ();
  always #12.5 i_clk_sys = ~i_clk_sys;
  msio_core msio_core_inst (.i_clk_sys, .i_rst, .i_instr, .port(port_if), .o_instr_taken, .o_carry, .o_zero,
    .o_int_rst);
  msio_user msio_user_inst (.i_clk_sys, .i_rst, .port(port_if), .i_in_data(in_data), .o_out_data(out_data),
    .o_read_done);
  msio_sva msio_sva_inst (.i_clk_sys, .i_rst, .port_select(port_if.port_select), .out_bus(port_if.out_bus),
    .read_strobe(port_if.read_strobe), .write_strobe(port_if.write_strobe), .o_instr_taken, .o_int_rst);
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input int n);
    i_rst = 1; c = 0; z = 0;
    // A stale word on the instruction input would run again after release
    i_instr = '0;
    foreach (m[k]) m[k] = RST_DATA;
    repeat (n) @(negedge i_clk_sys);
    i_rst = 0;
    repeat (RST_FILT + 2) @(negedge i_clk_sys);
    `CHK(o_int_rst, 1'b1)
    @(negedge i_clk_sys);
    `CHK(o_int_rst, 1'b0)
    repeat (8) @(negedge i_clk_sys);
  endtask
  // Ends on the negedge of the next fetch cycle, so calls chain back to back
  task automatic exec(input logic [15:0] ins, input logic rd, wr);
    for (int k = 0; k < 4 && o_instr_taken !== 1'b0; k++) @(negedge i_clk_sys);
    i_instr = ins;
    @(negedge i_clk_sys);
    `CHK(o_instr_taken, 1'b1)
    `CHK(port_if.read_strobe, rd)
    `CHK(port_if.write_strobe, wr)
    @(negedge i_clk_sys);
  endtask
  task automatic do_in(input logic [3:0] op, rg, input logic [7:0] f, input logic [1:0] pt, input logic [7:0] d);
    in_data[pt] = d;
    exec({op, rg, f}, 1'b1, 1'b0);
    `CHK(o_read_done, 1'b1)
    `CHK({o_carry, o_zero}, {c, z})
    m[rg] = d;
  endtask
  task automatic do_out(input logic [3:0] op, rg, input logic [7:0] f, pt);
    exec({op, rg, f}, 1'b0, 1'b1);
    `CHK(port_if.port_select, pt)
    `CHK(port_if.out_bus, m[rg])
    if (pt < 4) `CHK(out_data[pt[1:0]], m[rg])
    `CHK({o_carry, o_zero}, {c, z})
  endtask
  // Codes 2 and 4 pick the same bit in both directions: edge fill one way, rotate wrap the other
  function automatic logic [8:0] shf(input logic [7:0] v, input logic rt, input logic [2:0] s, input logic ci);
    logic f;
    case (s)
      3'h6: f = 1'b0;
      3'h7: f = 1'b1;
      3'h0: f = ci;
      3'h2: f = v[7];
      3'h4: f = v[0];
      default: f = 1'b0;
    endcase
    return rt ? {v[0], f, v[7:1]} : {v[7], v[6:0], f};
  endfunction
  task automatic do_sh(input logic [3:0] rg, input logic rt, input logic [2:0] s);
    logic [8:0] e;
    e = shf(m[rg], rt, s, c);
    exec({OPC_SHIFT, rg, 4'h0, rt, s}, 1'b0, 1'b0);
    c = e[8];
    z = (e[7:0] == 8'h00);
    m[rg] = e[7:0];
    `CHK({o_carry, o_zero}, {c, z})
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    foreach (in_data[k]) in_data[k] = 8'h00;
    do_reset(16);
    for (int k = 0; k < 16; k++) do_in(OPC_IN_K, 4'(k), 8'(k % 4), 2'(k), 8'($random(seed)));
    $display("test load done");
    for (int d = 0; d < 2; d++) for (int s = 0; s < 8; s++) begin
      r = 4'($random(seed));
      if (s == 6) do_in(OPC_IN_K, r, 8'h01, 2'h1, d ? 8'h01 : 8'h80);
      do_sh(r, d[0], 3'(s));
      do_out(OPC_OUT_K, r, 8'(s % 4), 8'(s % 4));
    end
    $display("test shift done");
    do_in(OPC_IN_K, 4'h5, 8'h02, 2'h2, 8'h03);
    do_in(OPC_IN_R, 4'h9, 8'h50, 2'h3, 8'ha5);
    do_out(OPC_OUT_R, 4'h9, 8'h50, 8'h03);
    do_out(OPC_OUT_K, 4'h9, 8'hff, 8'hff);
    do_out(OPC_OUT_K, 4'h5, 8'h00, 8'h00);
    $display("test port done");
    do_reset(3);
    `CHK({o_carry, o_zero}, 2'b00)
    do_in(OPC_IN_K, 4'h2, 8'h01, 2'h1, 8'h5a);
    do_out(OPC_OUT_K, 4'h2, 8'h01, 8'h01);
    $display("test reset done");
    tally_and_finish();
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule // mcu_shift_io_port_reset_bench
